//--- pwr_port_regs.v
// Power management, sleep delay and per-port control 0 register bank.
`include "pwr_port_consts.vh"
module pwr_port_regs #(
    parameter UNIT_CYCLES = `UNIT_CYCLES
) (
    // Clock and reset
    input  wire       clk,
    input  wire       rstn,
    // Register access from the management interface
    input  wire [7:0] reg_addr,
    input  wire       reg_wr,
    input  wire       reg_rd,
    input  wire [7:0] reg_wdata,
    output reg  [7:0] reg_rdata,
    // Energy detection from the PHYs
    input  wire       no_energy,
    // Power state outputs
    output reg        full_power_state,
    output reg        power_saving_state,
    output reg        energy_detect_state,
    output reg        soft_powerdown_state,
    output reg        low_power,
    output reg        pll_powerdown,
    // Per-port feature enables, bit n is port n+1
    output reg  [3:0] bcast_storm_en,
    output reg  [3:0] diffserv_en,
    output reg  [3:0] dot1p_en
);
    reg  [7:0] pmc_r;
    reg  [7:0] sleep_delay_r;
    wire [1:0] mode = pmc_r[`MODE_HI:`MODE_LO];
    wire       expired;
    wire [7:0] pctl [0:`NUM_PORTS-1];
    reg  [7:0] rdata_nxt;

    sleep_timer #(.UNIT_CYCLES(UNIT_CYCLES)) u_sleep (
        .clk       (clk),
        .rstn      (rstn),
        .armed     (mode == `MODE_ENERGY_DETECT),
        .no_energy (no_energy),
        .limit     (sleep_delay_r),
        .expired   (expired)
    );

    always @(posedge clk) begin
        if (!rstn) begin
            pmc_r         <= `PMC_RESET;
            sleep_delay_r <= `SLEEP_DELAY_RESET;
        end else if (reg_wr) begin
            if (reg_addr == `ADDR_POWER_MGMT_CTRL)
                // Only bits 5..3 are writable.
                pmc_r <= (reg_wdata & `PMC_RW_MASK)
                       | (`PMC_RSVD_VAL & ~`PMC_RW_MASK);
            if (reg_addr == `ADDR_SLEEP_DELAY_CTRL)
                sleep_delay_r <= reg_wdata;
        end
    end

    genvar p;
    generate
        for (p = 0; p < `NUM_PORTS; p = p + 1) begin : g_port
            reg  [7:0]  ctl_r;
            wire [31:0] base_w = `ADDR_PORT1_CTRL0 + p * `PORT_ADDR_STEP;
            wire        hit    = reg_wr && (reg_addr == base_w[7:0]);
            always @(posedge clk) begin
                if (!rstn) begin
                    ctl_r <= `PORT_CTRL0_RESET;
                end else if (hit) begin
                    ctl_r <= reg_wdata & `PORT_RW_MASK;
                end
            end
            assign pctl[p] = ctl_r;
            always @(posedge clk) begin
                if (!rstn) begin
                    bcast_storm_en[p] <= 1'b0;
                    diffserv_en[p]    <= 1'b0;
                    dot1p_en[p]       <= 1'b0;
                end else begin
                    bcast_storm_en[p] <= ctl_r[`BCAST_STORM_BIT];
                    diffserv_en[p]    <= ctl_r[`DIFFSERV_BIT];
                    dot1p_en[p]       <= ctl_r[`DOT1P_BIT];
                end
            end
        end
    endgenerate

    // Unmapped and reserved addresses, 0x10 among them, read as zero.
    always @* begin
        rdata_nxt = 8'h00;
        case (reg_addr)
            `ADDR_POWER_MGMT_CTRL:  rdata_nxt = pmc_r;
            `ADDR_SLEEP_DELAY_CTRL: rdata_nxt = sleep_delay_r;
            `ADDR_PORT1_CTRL0:      rdata_nxt = pctl[0];
            `ADDR_PORT2_CTRL0:      rdata_nxt = pctl[1];
            `ADDR_PORT3_CTRL0:      rdata_nxt = pctl[2];
            `ADDR_PORT4_CTRL0:      rdata_nxt = pctl[3];
            default:                rdata_nxt = 8'h00;
        endcase
    end

    always @(posedge clk) begin
        if (!rstn) begin
            reg_rdata            <= 8'h00;
            full_power_state     <= 1'b1;
            power_saving_state   <= 1'b0;
            energy_detect_state  <= 1'b0;
            soft_powerdown_state <= 1'b0;
            low_power            <= 1'b0;
            pll_powerdown        <= 1'b0;
        end else begin
            if (reg_rd)
                reg_rdata <= rdata_nxt;
            full_power_state     <= (mode == `MODE_NORMAL);
            energy_detect_state  <= (mode == `MODE_ENERGY_DETECT);
            soft_powerdown_state <= (mode == `MODE_SOFT_PD);
            power_saving_state   <= (mode == `MODE_POWER_SAVING);
            low_power            <= (mode == `MODE_ENERGY_DETECT) & expired;
            // The PLL may only stop once asleep in energy-detect mode.
            pll_powerdown <= (mode == `MODE_ENERGY_DETECT) & expired
                           & ~pmc_r[`PLL_PD_BIT];
        end
    end
endmodule // pwr_port_regs

//--- pwr_port_consts.vh
// Constants for the power management and port control register block.
// Operation
// - Bit5 clear enables PLL power-down, resets 0.
// - PLL power-down acts only in energy-detect.
// - Mode field 00/01/10/11 selects four power states.
// - Sleep after sleep_delay times 20 ms no-energy.
// - Sleep delay eight-bit RW, reset 0x50.
// - Port registers at 0x20..0x50; 0x10 reserved.
// - Bit7 enables broadcast storm protection per port.
// - Bit6 enables DiffServ classification per port.
// - Bit5 enables 802.1p classification per port.
`ifndef PWR_PORT_CONSTS_VH
`define PWR_PORT_CONSTS_VH
`define ADDR_POWER_MGMT_CTRL  8'h0E
`define ADDR_SLEEP_DELAY_CTRL 8'h0F
`define ADDR_PORT_RSVD        8'h10
`define ADDR_PORT1_CTRL0      8'h20
`define ADDR_PORT2_CTRL0      8'h30
`define ADDR_PORT3_CTRL0      8'h40
`define ADDR_PORT4_CTRL0      8'h50
`define PORT_ADDR_STEP        8'h10
`define NUM_PORTS             4
`define PLL_PD_BIT            5
`define MODE_HI               4
`define MODE_LO               3
`define BCAST_STORM_BIT       7
`define DIFFSERV_BIT          6
`define DOT1P_BIT             5
`define PORT_RW_MASK          8'hFF
`define PMC_RW_MASK           8'h38
`define PMC_RSVD_VAL          8'h00
`define PMC_RESET             8'h00
`define SLEEP_DELAY_RESET     8'h50
`define PORT_CTRL0_RESET      8'h00
`define MODE_NORMAL           2'h0
`define MODE_ENERGY_DETECT    2'h1
`define MODE_SOFT_PD          2'h2
`define MODE_POWER_SAVING     2'h3
`define UNIT_TIME_MS          20
`define CLK_MHZ               200
`define UNIT_CYCLES (`UNIT_TIME_MS * 1000 * `CLK_MHZ)
`define UNIT_CNT_W            22
`endif

//--- unit_tick.v
// Divider that emits a one-cycle pulse once per sleep-delay time unit.
`include "pwr_port_consts.vh"
module unit_tick #(
    parameter UNIT_CYCLES = `UNIT_CYCLES
) (
    // Clock and reset
    input  wire clk,
    input  wire rstn,
    // Control
    input  wire run,
    output reg  tick
);
    localparam integer LAST_I = UNIT_CYCLES - 1;
    reg  [`UNIT_CNT_W-1:0] cnt_r;
    wire [31:0]            last_w = LAST_I;
    // Only the low bits matter, since the count never reaches the upper ones.
    wire [`UNIT_CNT_W-1:0] last = last_w[`UNIT_CNT_W-1:0];

    always @(posedge clk) begin
        if (!rstn || !run) begin
            cnt_r <= {`UNIT_CNT_W{1'b0}};
            tick  <= 1'b0;
        end else if (cnt_r == last) begin
            cnt_r <= {`UNIT_CNT_W{1'b0}};
            tick  <= 1'b1;
        end else begin
            cnt_r <= cnt_r + {{(`UNIT_CNT_W-1){1'b0}}, 1'b1};
            tick  <= 1'b0;
        end
    end
endmodule // unit_tick

//--- sleep_timer.v
// Counts whole time units of uninterrupted no-energy and flags sleep.
`include "pwr_port_consts.vh"
module sleep_timer #(
    parameter UNIT_CYCLES = `UNIT_CYCLES
) (
    // Clock and reset
    input  wire       clk,
    input  wire       rstn,
    // Condition and limit
    input  wire       armed,
    input  wire       no_energy,
    input  wire [7:0] limit,
    output reg        expired
);
    wire       tick;
    reg  [8:0] units_r;
    wire       run = armed & no_energy;

    unit_tick #(.UNIT_CYCLES(UNIT_CYCLES)) u_tick (
        .clk  (clk),
        .rstn (rstn),
        .run  (run),
        .tick (tick)
    );

    // Any energy or leaving the mode restarts the count from zero.
    always @(posedge clk) begin
        if (!rstn || !run) begin
            units_r <= 9'h000;
            expired <= 1'b0;
        end else begin
            if (tick && !expired)
                units_r <= units_r + 9'h001;
            expired <= (units_r >= {1'b0, limit});
        end
    end
endmodule // sleep_timer

//--- pwr_port_chk.sv
// Assertions on the power and port control register bank ports.
module pwr_port_chk #(parameter UNIT_CYCLES = 4) (
    // Clock, reset, register access and state
    input logic       clk,
    input logic       rstn,
    input logic [7:0] reg_addr,
    input logic       reg_wr,
    input logic       reg_rd,
    input logic [7:0] reg_wdata,
    input logic [7:0] reg_rdata,
    input logic       energy_detect_state,
    input logic       low_power,
    input logic       pll_powerdown,
    input logic [3:0] bcast_storm_en
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    unmapped_rd_a: assert property (reg_rd && reg_addr == 8'h10
        |=> reg_rdata == 8'h00) else $error("unmapped read");
    rsvd_bits_a: assert property (reg_rd && reg_addr == 8'h0e
        |=> (reg_rdata & 8'hc7) == 8'h00) else $error("reserved bits");
    rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("rdata moved");
    ed_enter_a: assert property (reg_wr && reg_addr == 8'h0e &&
        reg_wdata[4:3] == 2'h1 ##1 !reg_wr |=> energy_detect_state)
        else $error("mode decode");
    ed_leave_a: assert property (reg_wr && reg_addr == 8'h0e &&
        reg_wdata[4:3] != 2'h1 ##1 !reg_wr |=> !energy_detect_state)
        else $error("mode decode");
    bcast_a: assert property (reg_wr && reg_addr == 8'h20
        ##1 !reg_wr |=> bcast_storm_en[0] == $past(reg_wdata[7], 2))
        else $error("storm enable");
    pll_pd_a: assert property (pll_powerdown |->
        low_power || $past(low_power)) else $error("pll without sleep");
    sleep_ed_a: assert property (low_power |->
        energy_detect_state || $past(energy_detect_state) ||
        $past(energy_detect_state, 2)) else $error("sleep outside mode");
    sleep_c: cover property (low_power);
    pll_c: cover property (pll_powerdown);
    unmapped_c: cover property (reg_rd && reg_addr == 8'h10);
endmodule // pwr_port_chk

bind pwr_port_regs pwr_port_chk #(.UNIT_CYCLES(UNIT_CYCLES)) i_chk (
    .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .energy_detect_state(energy_detect_state), .low_power(low_power),
    .pll_powerdown(pll_powerdown), .bcast_storm_en(bcast_storm_en));

//--- pwr_port_regs_tb.sv
// Self-checking bench for the power and port control register bank.
module pwr_port_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [3:0] mode_st [4] = '{4'h1, 4'h4, 4'h8, 4'h2};
    logic       clk = 0, rstn = 0, wr_s = 0, rd_s = 0, ne = 0;
    logic [7:0] addr = 8'h00, wd = 8'h00, rdat;
    logic [3:0] st, bc, ds, dp;
    logic       lp, pd;
    int         error_cnt = 0, compares = 0, cyc = 0;
    pwr_port_regs #(.UNIT_CYCLES(4)) i_dut (.clk(clk), .rstn(rstn),
        .reg_addr(addr), .reg_wr(wr_s), .reg_rd(rd_s), .reg_wdata(wd),
        .reg_rdata(rdat), .no_energy(ne), .full_power_state(st[0]),
        .power_saving_state(st[1]), .energy_detect_state(st[2]),
        .soft_powerdown_state(st[3]), .low_power(lp), .pll_powerdown(pd),
        .bcast_storm_en(bc), .diffserv_en(ds), .dot1p_en(dp));
    task automatic chk(input string n, input logic [7:0] s, e);
        compares++;
        if (s !== e) begin
            error_cnt++;
            $display("unexpected %s exp %h seen %h", n, e, s);
        end
    endtask
    // One strobe cycle, then a spare edge so registered outputs settle.
    task automatic acc(input logic w, input logic [7:0] a, d);
        @(posedge clk);
        #1 {wr_s, rd_s, addr, wd} = {w, !w, a, d};
        @(posedge clk);
        #1 {wr_s, rd_s} = 2'h0;
        @(posedge clk);
        #1;
    endtask
    task automatic results;
        $display("checks %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        #1 rstn = 1;
        chk("state", {4'h0, st}, 8'h01);
        acc(0, 8'h0f, 8'h00);
        chk("delay", rdat, 8'h50);
        acc(0, 8'h0e, 8'h00);
        chk("pmc", rdat, 8'h00);
        acc(1, 8'h10, 8'hff);
        acc(0, 8'h10, 8'h00);
        chk("unmapped", rdat, 8'h00);
        acc(0, 8'h0f, 8'h00);
        chk("delay", rdat, 8'h50);
        acc(1, 8'h0e, 8'hff);
        acc(0, 8'h0e, 8'h00);
        chk("pmc", rdat, 8'h38);
        for (int m = 0; m < 4; m++) begin
            acc(1, 8'h0e, 8'(m << 3));
            chk("mode", {4'h0, st}, {4'h0, mode_st[m]});
        end
        for (int p = 0; p < 4; p++) begin
            chk("port", {bc, ds}, {2{4'hf >> (4 - p)}});
            acc(1, 8'(8'h20 + 8'h10 * p), 8'he0);
        end
        acc(1, 8'h30, 8'h40);
        chk("port", {bc, ds}, 8'hdf);
        chk("dot1p", {4'h0, dp}, 8'h0d);
        acc(0, 8'h30, 8'h00);
        chk("port rd", rdat, 8'h40);
        acc(1, 8'h0f, 8'h02);
        ne = 1;
        acc(1, 8'h0e, 8'h08);
        repeat (3) @(posedge clk);
        #1 chk("sleep", {6'h0, lp, pd}, 8'h00);
        repeat (20) @(posedge clk);
        #1 chk("sleep", {6'h0, lp, pd}, 8'h03);
        acc(1, 8'h0e, 8'h28);
        chk("pll", {7'h0, pd}, 8'h00);
        acc(1, 8'h0e, 8'h18);
        chk("pll", {7'h0, pd}, 8'h00);
        results;
    end
    initial forever #2.5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 1000) begin
            error_cnt++;
            results;
        end
    end
endmodule // pwr_port_regs_tb
